// file: core/tsicm_core.sv
// Connection memory control core of a time-slot interchange switch.
// Assumes slot_tick and frame_start come from logic on hclk, one slot
// lasting at least STREAMS+2 cycles, and rx_slot_data stands at slot_tick.
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "tsicm_defs.svh"

module tsicm_core #(
    parameter int STREAMS  = 32,
    parameter int CHANNELS = 32
) (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     ce,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    input  wire logic                     output_drive_master_pin,
    input  wire logic                     slot_tick,
    input  wire logic                     frame_start,
    input  wire logic [STREAMS-1:0][7:0]  rx_slot_data,
    output logic [STREAMS-1:0][7:0]       tx_slot_data,
    output logic [STREAMS-1:0]            tx_slot_oe,
    output logic [4:0]                    tx_channel,
    output logic                          tx_slot_valid
);

    localparam int CM_WORDS = STREAMS * CHANNELS;
    localparam int DM_WORDS = 4096;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0]             cm [0:CM_WORDS-1];
    logic [7:0]              dm [0:DM_WORDS-1];
    logic [15:0]             cr;
    logic [15:0]             frame_align;
    logic [15:0]             frame_offset [0:`TSICM_FOR_COUNT-1];

    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    logic                    wr_phase;
    logic [11:0]             wr_addr;
    logic                    take;
    logic [11:0]             req_addr;
    logic [15:0]             read_value;
    logic                    reg_wr;
    logic                    cm_cpu_wr;
    logic [3:0]              reg_idx;

    // ------------------------------------------------------------
    // Switching state
    // ------------------------------------------------------------
    tsicm_pkg::tsicm_walk_t  walk;
    tsicm_pkg::tsicm_walk_t  next_walk;
    logic [4:0]              cur_ch;
    logic [1:0]              page_cur;
    logic [1:0]              page_prev;
    logic [1:0]              page_old;
    logic [4:0]              walk_s;
    logic [STREAMS-1:0][7:0] rx_hold;
    tsicm_pkg::tsicm_cm_word_t cmw;
    logic [1:0]              src_page;
    logic [7:0]              src_byte;
    logic [7:0]              tx_byte;
    logic                    same_frame;
    logic                    master_en;
    logic                    ode_meta;
    logic                    ode_sync;

    // ------------------------------------------------------------
    // Bulk fill
    // ------------------------------------------------------------
    logic                    fill_start;
    logic                    fill_busy;
    logic                    fill_done;
    tsicm_pkg::tsicm_cm_wr_t fill_wr;

    assign fill_start = cr[`TSICM_CR_GO] & cr[`TSICM_CR_ARM] & ~fill_busy & ~fill_done;

    tsicm_fill #(
        .ADDR_W (10)
    ) u_fill (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .start   (fill_start),
        .pattern (cr[`TSICM_CR_PAT_HI:`TSICM_CR_PAT_LO]),
        .busy    (fill_busy),
        .done    (fill_done),
        .wr      (fill_wr)
    );

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Writes take one wait state so a following read sees the new value
    assign hreadyout = ce & ~wr_phase;
    assign hresp     = 1'b0;
    assign take      = ce & hsel & htrans[1] & hready;
    assign req_addr  = haddr[13:2];
    assign reg_idx   = wr_addr[9:6];
    assign reg_wr    = ce & wr_phase & (wr_addr[11:10] == `TSICM_SPACE_REG);
    assign cm_cpu_wr = ce & wr_phase & (wr_addr[11:10] == `TSICM_SPACE_CM);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_phase <= 1'b0;
            wr_addr  <= 12'h000;
        end else if (ce) begin
            if (wr_phase) begin
                wr_phase <= 1'b0;
            end else if (take && hwrite) begin
                wr_phase <= 1'b1;
                wr_addr  <= req_addr;
            end
        end
    end

    always_comb begin
        read_value = 16'h0000;
        unique case (req_addr[11:10])
            `TSICM_SPACE_DM:  read_value = {8'h00, dm[{page_cur, req_addr[9:0]}]};
            `TSICM_SPACE_CM:  read_value = cm[req_addr[9:0]];
            `TSICM_SPACE_REG: begin
                if (req_addr[9:6] == `TSICM_REG_CR) begin
                    read_value = cr;
                end else if (req_addr[9:6] == `TSICM_REG_FAR) begin
                    read_value = frame_align;
                end else if (req_addr[9:6] < (`TSICM_REG_FOR0 + 4'(`TSICM_FOR_COUNT))) begin
                    read_value = frame_offset[3'(req_addr[9:6] - `TSICM_REG_FOR0)];
                end
            end
            default:          read_value = 16'h0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= {16'h0000, read_value};
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cr <= `TSICM_CR_RESET;
        end else if (reg_wr && reg_idx == `TSICM_REG_CR) begin
            cr <= hwdata[15:0] & `TSICM_CR_MASK;
            // go accepted only with arm set
            cr[`TSICM_CR_GO] <= (hwdata[`TSICM_CR_GO] & hwdata[`TSICM_CR_ARM]) | fill_busy;
        end else if (ce && fill_done) begin
            cr[`TSICM_CR_GO] <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_align <= 16'h0000;
        end else if (reg_wr && reg_idx == `TSICM_REG_FAR) begin
            frame_align <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `TSICM_FOR_COUNT; i++) begin
                frame_offset[i] <= 16'h0000;
            end
        end else if (reg_wr && reg_idx >= `TSICM_REG_FOR0 &&
                     reg_idx < (`TSICM_REG_FOR0 + 4'(`TSICM_FOR_COUNT))) begin
            frame_offset[3'(reg_idx - `TSICM_REG_FOR0)] <= hwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Connection memory writes
    // ------------------------------------------------------------
    // fill writes only here; processor write dropped while filling
    always_ff @(posedge hclk) begin
        if (fill_wr.we) begin
            cm[fill_wr.addr] <= fill_wr.data;
        end else if (cm_cpu_wr) begin
            cm[wr_addr[9:0]] <= hwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Output drive pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ode_meta <= 1'b0;
            ode_sync <= 1'b0;
        end else if (ce) begin
            ode_meta <= output_drive_master_pin;
            ode_sync <= ode_meta;
        end
    end

    assign master_en = ode_sync | cr[`TSICM_CR_STBY];

    // ------------------------------------------------------------
    // Frame and slot tracking
    // ------------------------------------------------------------
    // 32 channels per frame, one tick per slot both ways
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ch   <= 5'h00;
            page_cur <= 2'h0;
            rx_hold  <= '0;
        end else if (ce && slot_tick && walk == tsicm_pkg::TSICM_IDLE) begin
            rx_hold <= rx_slot_data;
            if (frame_start) begin
                cur_ch   <= 5'h00;
                page_cur <= (page_cur == `TSICM_PAGE_LAST) ? 2'h0 : page_cur + 2'h1;
            end else begin
                cur_ch <= cur_ch + 5'h01;
            end
        end
    end

    assign page_prev = (page_cur == 2'h0) ? `TSICM_PAGE_LAST : page_cur - 2'h1;
    assign page_old  = (page_cur == `TSICM_PAGE_LAST) ? 2'h0 : page_cur + 2'h1;

    // ------------------------------------------------------------
    // Switching walk, one output stream per cycle
    // ------------------------------------------------------------
    always_comb begin
        next_walk = walk;
        unique case (walk)
            tsicm_pkg::TSICM_IDLE: begin
                if (slot_tick) begin
                    next_walk = tsicm_pkg::TSICM_WALK;
                end
            end
            tsicm_pkg::TSICM_WALK: begin
                if (walk_s == 5'(STREAMS - 1)) begin
                    next_walk = tsicm_pkg::TSICM_DONE;
                end
            end
            tsicm_pkg::TSICM_DONE: next_walk = tsicm_pkg::TSICM_IDLE;
            default:               next_walk = tsicm_pkg::TSICM_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            walk   <= tsicm_pkg::TSICM_IDLE;
            walk_s <= 5'h00;
        end else if (ce) begin
            walk <= next_walk;
            if (walk == tsicm_pkg::TSICM_WALK) begin
                walk_s <= walk_s + 5'h01;
            end else begin
                walk_s <= 5'h00;
            end
        end
    end

    always_comb begin
        cmw        = tsicm_pkg::tsicm_cm_word_t'(cm[{walk_s, cur_ch}]);
        // channel numbers only decide the delay
        // three slots apart or more stays in the frame
        same_frame = ({1'b0, cur_ch} >= ({1'b0, cmw.source_channel_field} + `TSICM_VAR_MIN_SLOTS));
        // constant delay reads the page two frames back
        if (cmw.delay_const) begin
            src_page = page_old;
        end else if (same_frame) begin
            src_page = page_cur;
        end else begin
            src_page = page_prev;
        end
        src_byte = dm[{src_page, cmw.source_stream_field, cmw.source_channel_field}];
        tx_byte  = cmw.source_cpu ? cm[{walk_s, cur_ch}][7:0] : src_byte;
    end

    // loopback writes sent byte as received data
    // data memory fed regardless of fill
    always_ff @(posedge hclk) begin
        if (ce && walk == tsicm_pkg::TSICM_WALK) begin
            dm[{page_cur, walk_s, cur_ch}] <= cmw.loop_back ? tx_byte : rx_hold[walk_s];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_slot_data <= '0;
            tx_slot_oe   <= '0;
        end else if (ce && walk == tsicm_pkg::TSICM_WALK) begin
            tx_slot_data[walk_s] <= tx_byte;
            tx_slot_oe[walk_s]   <= cmw.out_en & master_en;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_slot_valid <= 1'b0;
            tx_channel    <= 5'h00;
        end else if (ce) begin
            tx_slot_valid <= (walk == tsicm_pkg::TSICM_DONE);
            if (walk == tsicm_pkg::TSICM_DONE) begin
                tx_channel <= cur_ch;
            end
        end
    end

endmodule

// file: core/tsicm_defs.svh
// Constants of the connection memory control core: decode, field positions,
// reset values and timing figures.
// Assumes inclusion by bare name from the core and fill modules.
`ifndef TSICM_DEFS_SVH
`define TSICM_DEFS_SVH

// Address space select, processor address bits 11:10
`define TSICM_SPACE_DM      2'b11
`define TSICM_SPACE_CM      2'b10
`define TSICM_SPACE_REG     2'b01

// Register index, processor address bits 9:6
`define TSICM_REG_CR        4'h0
`define TSICM_REG_FAR       4'h1
`define TSICM_REG_FOR0      4'h2
`define TSICM_FOR_COUNT     8

// Control register fields
`define TSICM_CR_ARM        9
`define TSICM_CR_PAT_HI     8
`define TSICM_CR_PAT_LO     5
`define TSICM_CR_GO         4
`define TSICM_CR_STBY       3
`define TSICM_CR_SFE        2
`define TSICM_CR_RESET      16'h0000
`define TSICM_CR_MASK       16'h03fc

// Connection memory fill value of the low field
`define TSICM_CM_LOW_FILL   12'h000

// Variable delay: least distance in time-slots for same-frame output
`define TSICM_VAR_MIN_SLOTS 6'h03

// Data memory pages for constant delay
`define TSICM_PAGES         2'h3
`define TSICM_PAGE_LAST     2'h2

`endif

// file: core/tsicm_pkg.sv
// Types of the connection memory control core.
// Assumes tsicm_defs.svh is on the include path.
package tsicm_pkg;

    // Connection memory word
    typedef struct packed {
        logic       loop_back;
        logic       delay_const;
        logic       source_cpu;
        logic       out_en;
        logic [1:0] spare;
        logic [4:0] source_stream_field;
        logic [4:0] source_channel_field;
    } tsicm_cm_word_t;

    // One connection memory write
    typedef struct packed {
        logic        we;
        logic [9:0]  addr;
        logic [15:0] data;
    } tsicm_cm_wr_t;

    // Per-slot switching walk
    typedef enum logic [2:0] {
        TSICM_IDLE = 3'b001,
        TSICM_WALK = 3'b010,
        TSICM_DONE = 3'b100
    } tsicm_walk_t;

endpackage

// file: core/tsicm_fill.sv
// Bulk fill sequencer: writes one connection memory word per enabled cycle.
// Assumes the owner gives its writes priority over processor writes.
`timescale 1ns/1ps
`include "tsicm_defs.svh"

module tsicm_fill #(
    parameter int ADDR_W = 10
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  ce,
    input  wire logic                  start,
    input  wire logic [3:0]            pattern,
    output logic                       busy,
    output logic                       done,
    output tsicm_pkg::tsicm_cm_wr_t    wr
);

    logic [ADDR_W-1:0] addr;
    logic [3:0]        pat;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            done <= 1'b0;
            addr <= '0;
            pat  <= 4'h0;
        end else if (ce) begin
            done <= 1'b0;
            if (!busy && start) begin
                busy <= 1'b1;
                addr <= '0;
                pat  <= pattern;
            end else if (busy) begin
                addr <= addr + 1'b1;
                // fill ends well in two frames
                if (addr == {ADDR_W{1'b1}}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    always_comb begin
        wr.we   = busy & ce;
        wr.addr = addr[9:0];
        wr.data = {pat, `TSICM_CM_LOW_FILL};
    end

endmodule

// file: sim/tsicm_monitor.sv
// Checker of bus timing and slot walk pacing of tsicm_core.
// Assumes it is bound into tsicm_core and hready is tied to hreadyout.
`timescale 1ns/1ps
module tsicm_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        slot_tick,
    input wire logic        frame_start,
    input wire logic [4:0]  tx_channel,
    input wire logic        tx_slot_valid
);
    logic [5:0] busy_n;
    logic [4:0] last_ch;
    logic       seen;
    logic       take;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    assign take = ce & hsel & htrans[1] & hready;

    // Walk occupancy after an accepted tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_n <= 6'h00;
        end else if (ce && slot_tick && busy_n == 6'h00) begin
            busy_n <= 6'h22;
        end else if (ce && busy_n != 6'h00) begin
            busy_n <= busy_n - 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_ch <= 5'h00;
            seen <= 1'b0;
        end else if (tx_slot_valid) begin
            last_ch <= tx_channel;
            seen <= 1'b1;
        end
    end

    chk_write_wait: assert property (take && hwrite |=> !hreadyout ##1 hreadyout)
        else $error("write data phase wait wrong");
    chk_read_ready: assert property (take && !hwrite |=> hreadyout)
        else $error("read data phase not ready");
    chk_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without read");
    chk_resp_okay: assert property (!hresp && hrdata[31:16] == 16'h0000)
        else $error("response or upper data wrong");
    chk_slot_latency: assert property (ce && slot_tick && busy_n == 6'h00 |-> ##34 tx_slot_valid)
        else $error("slot result late or missing");
    chk_valid_cause: assert property (tx_slot_valid |-> $past(slot_tick, 34))
        else $error("slot result without tick");
    chk_valid_pulse: assert property (tx_slot_valid |=> !tx_slot_valid)
        else $error("slot valid longer than a cycle");
    chk_frame_zero: assert property (tx_slot_valid && $past(frame_start, 34) |-> tx_channel == 5'h00)
        else $error("frame start not channel zero");
    chk_channel_step: assert property (tx_slot_valid && seen && !$past(frame_start, 34)
        |-> tx_channel == last_ch + 5'h01)
        else $error("channel number did not step");
endmodule

bind tsicm_core tsicm_monitor u_mon (.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .slot_tick, .frame_start, .tx_channel, .tx_slot_valid);

// file: sim/tsicm_slot_src.sv
// Slot source standing for the serial receive side of tsicm_core.
// Assumes one slot per 40 hclk cycles and 32 channels per frame.
`timescale 1ns/1ps
module tsicm_slot_src #(
    parameter int STREAMS = 32
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    output logic                    slot_tick,
    output logic                    frame_start,
    output logic [STREAMS-1:0][7:0] rx_slot_data
);
    logic [5:0] cyc;
    logic [4:0] ch;
    int         fr;

    function automatic logic [7:0] rxb(input int f, input int s, input int c);
        return 8'(f * 37 + s * 5 + c * 3);
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc <= 6'h00;
            ch <= 5'h00;
            fr <= 0;
            slot_tick <= 1'b0;
            frame_start <= 1'b0;
            rx_slot_data <= '0;
        end else begin
            cyc <= (cyc == 6'h27) ? 6'h00 : cyc + 6'h01;
            slot_tick <= (cyc == 6'h00);
            frame_start <= (cyc == 6'h00) && (ch == 5'h00);
            rx_slot_data <= ~rx_slot_data;
            if (cyc == 6'h00) begin
                ch <= ch + 5'h01;
                fr <= fr + int'(ch == 5'h00);
                for (int s = 0; s < STREAMS; s++) begin
                    rx_slot_data[s] <= rxb(fr + int'(ch == 5'h00), s, int'(ch));
                end
            end
        end
    end
endmodule

// file: sim/tsicm_core_test.sv
// Self-checking bench of tsicm_core: registers, bulk fill, switching, gating.
// Assumes tsicm_slot_src paces slots 40 cycles apart.
`timescale 1ns/1ps
module tsicm_core_test;
    localparam int SLOT = 40;
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic             hwrite;
    logic             drive_pin;
    logic [1:0]       htrans;
    logic [31:0]      haddr;
    logic [31:0]      hwdata;
    logic             hreadyout;
    logic             hresp;
    logic [31:0]      hrdata;
    logic             slot_tick;
    logic             frame_start;
    logic [31:0][7:0] rx;
    logic [31:0][7:0] tx_d;
    logic [31:0]      tx_oe;
    logic [4:0]       tx_ch;
    logic             tx_v;
    logic [15:0]      q;
    logic [15:0]      v;
    logic [9:0]       a;
    logic [7:0]       b;
    logic [7:0]       lb;
    logic [3:0]       pat;
    int               seed;
    int               t0;
    int               f;
    int               cyc = 0;
    int               num_errors = 0;
    int               comparisons = 0;

    tsicm_core dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .output_drive_master_pin(drive_pin), .slot_tick,
        .frame_start, .rx_slot_data(rx), .tx_slot_data(tx_d), .tx_slot_oe(tx_oe), .tx_channel(tx_ch),
        .tx_slot_valid(tx_v));
    tsicm_slot_src src (.hclk, .hresetn, .slot_tick, .frame_start, .rx_slot_data(rx));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Byte the slot source sends for a frame, stream and channel
    function automatic logic [7:0] rxb(input int fr, input int s, input int c);
        return 8'(fr * 37 + s * 5 + c * 3);
    endfunction

    task automatic bus(input logic w, input logic [11:0] ad, input logic [15:0] d, output logic [15:0] r);
        logic rdy;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {18'h00000, ad, 2'h0};
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            @(posedge hclk);
        end while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            r = hrdata[15:0];
            @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask

    task automatic wr(input logic [11:0] ad, input logic [15:0] d);
        logic [15:0] s;
        bus(1'b1, ad, d, s);
    endtask

    task automatic rdc(input logic [11:0] ad, input logic [15:0] e);
        logic [15:0] s;
        bus(1'b0, ad, 16'h0000, s);
        chk(s, e);
    endtask

    task automatic slot(input logic [4:0] m);
        do @(negedge hclk); while (!(tx_v === 1'b1 && tx_ch === m));
    endtask

    initial begin
        seed = 32'h5a80;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        drive_pin = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(12'h400, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed)) & 16'h03ec;
            wr(12'h400, v);
            rdc(12'h400, v);
        end
        wr(12'h680, 16'hffff);
        rdc(12'h680, 16'h0000);
        wr(12'h055, 16'hffff);
        rdc(12'h055, 16'h0000);
        v = 16'($random(seed));
        wr(12'h440, v);
        rdc(12'h440, v);
        wr(12'h640, v);
        rdc(12'h640, v);
        // Offset back to zero before loopback is used
        wr(12'h640, 16'h0000);
        rdc(12'h640, 16'h0000);
        wr(12'h400, 16'h0010);
        rdc(12'h400, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            a = 10'($random(seed));
            v = 16'($random(seed)) & 16'hf3ff;
            wr({2'h2, a}, v);
            rdc({2'h2, a}, v);
        end
        $display("test registers done");
        // Random pattern first, then zero so no stray loopback or mode stays behind
        for (int j = 0; j < 2; j++) begin
            pat = (j == 0) ? 4'($random(seed)) : 4'h0;
            t0 = cyc;
            wr(12'h400, {6'h00, 1'b1, pat, 5'h10});
            q = 16'h0010;
            for (int k = 0; k < 900 && q[4]; k++) bus(1'b0, 12'h400, 16'h0000, q);
            chk(16'(q[4]), 16'h0000);
            chk(16'(cyc - t0 <= 2 * 32 * SLOT), 16'h0001);
            rdc(12'h800, {pat, 12'h000});
            rdc(12'hbff, {pat, 12'h000});
            rdc({2'h2, a}, {pat, 12'h000});
        end
        wr(12'h400, 16'h0000);
        $display("test bulk fill done");
        b = 8'($random(seed));
        lb = 8'($random(seed));
        wr(12'h8aa, {8'h30, b});
        wr(12'h8ab, {8'h20, b});
        wr(12'h8b4, 16'h10e4);
        wr(12'h8b5, 16'h10f6);
        wr(12'h8b6, 16'h50e4);
        wr(12'h8ad, {8'hb0, lb});
        wr(12'h8b7, 16'h10ad);
        wr(12'h8b8, 16'h10f5);
        wr(12'h8b9, 16'h10f7);
        @(posedge hclk);
        drive_pin <= 1'b1;
        f = src.fr;
        while (src.fr < f + 3) @(posedge hclk);
        slot(5'h0a);
        chk(16'(tx_d[5]), 16'(b));
        chk(16'(tx_oe[5]), 16'h0001);
        slot(5'h0b);
        chk(16'(tx_oe[5]), 16'h0000);
        slot(5'h14);
        chk(16'(tx_d[5]), 16'(rxb(src.fr, 7, 4)));
        slot(5'h15);
        chk(16'(tx_d[5]), 16'(rxb(src.fr - 1, 7, 22)));
        slot(5'h16);
        chk(16'(tx_d[5]), 16'(rxb(src.fr - 2, 7, 4)));
        slot(5'h17);
        chk(16'(tx_d[5]), 16'(lb));
        rdc(12'hcad, {8'h00, lb});
        slot(5'h18);
        chk(16'(tx_d[5]), 16'(rxb(src.fr, 7, 21)));
        slot(5'h19);
        chk(16'(tx_d[5]), 16'(rxb(src.fr - 1, 7, 23)));
        slot(5'h0a);
        chk(16'(tx_d[5]), 16'(b));
        $display("test switching done");
        @(posedge hclk);
        drive_pin <= 1'b0;
        slot(5'h0a);
        slot(5'h0a);
        chk(16'(tx_oe[5]), 16'h0000);
        wr(12'h400, 16'h0008);
        slot(5'h0a);
        slot(5'h0a);
        chk(16'(tx_oe[5]), 16'h0001);
        $display("test output gating done");
        end_sim();
    end
endmodule
